// >>> msl_params.svh
/*
 * Offsets, field positions, depths and timing figures of the
 * serial line parameter block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MSL_PARAMS_SVH
`define MSL_PARAMS_SVH

// Register selects on the host register port
`define MSL_SEL_LPAR_RXBUF  2'h0
`define MSL_SEL_TCTRL       2'h1
`define MSL_SEL_TDATA_MSTAT 2'h2

// Line parameter word fields
`define MSL_LP_LINE_LSB     0
`define MSL_LP_LEN_LSB      3
`define MSL_LP_STOP_BIT     5
`define MSL_LP_PAR_BIT      6
`define MSL_LP_ODD_BIT      7
`define MSL_LP_SPD_LSB      8
`define MSL_LP_RXON_BIT     12

// Receive buffer word fields
`define MSL_RB_LINE_LSB     8
`define MSL_RB_PERR_BIT     12
`define MSL_RB_FERR_BIT     13
`define MSL_RB_OVR_BIT      14
`define MSL_RB_VALID_BIT    15

// Baud rates in tenths of a baud, code 0 upward
`define MSL_BAUD10_0        500
`define MSL_BAUD10_1        750
`define MSL_BAUD10_2        1100
`define MSL_BAUD10_3        1345
`define MSL_BAUD10_4        1500
`define MSL_BAUD10_5        3000
`define MSL_BAUD10_6        6000
`define MSL_BAUD10_7        12000
`define MSL_BAUD10_8        18000
`define MSL_BAUD10_9        20000
`define MSL_BAUD10_10       24000
`define MSL_BAUD10_11       36000
`define MSL_BAUD10_12       48000
`define MSL_BAUD10_13       72000
`define MSL_BAUD10_14       96000

`define MSL_OVERSAMPLE      16
`define MSL_CLK_HZ          10000000
`define MSL_ALARM_COUNT     5'h10
`define MSL_SILO_DEPTH      64
`define MSL_TXBUF_DEPTH     2

`endif

// >>> msl_pkg.sv
/*
 * Types shared by the serial line parameter block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package msl_pkg;

	typedef logic [2:0] msl_line_t;

	typedef enum logic [1:0] {
		MSL_LEN5 = 2'b00,
		MSL_LEN6 = 2'b01,
		MSL_LEN7 = 2'b10,
		MSL_LEN8 = 2'b11
	} msl_len_t;

	typedef struct packed {
		logic       rx_on;
		logic [3:0] speed;
		logic       odd;
		logic       par_en;
		logic       stop2;
		msl_len_t   len;
	} msl_lparam_t;

endpackage

// >>> msl_fifo.sv
/*
 * Small synchronous FIFO with a registered output stage.
 * Assumes one clock; clr_i empties it like a reset.
 */
`timescale 1ns/1ps
module msl_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic             clr_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("msl_fifo depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wptr_ff;
	logic [AW-1:0]    rptr_ff;
	logic [AW:0]      cnt_ff;
	logic [AW:0]      nxt_cnt;
	logic             push;
	logic             pop;

	assign push = in_valid_i && in_ready_o;
	assign pop  = (cnt_ff != '0) && (!out_valid_o || out_ready_i);

	always_comb begin
		nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wptr_ff] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i || clr_i) begin
			wptr_ff    <= '0;
			rptr_ff    <= '0;
			cnt_ff     <= '0;
			in_ready_o <= 1'b0;
		end else begin
			wptr_ff    <= wptr_ff + AW'(push);
			rptr_ff    <= rptr_ff + AW'(pop);
			cnt_ff     <= nxt_cnt;
			// Registered ready; a full store refuses until a word leaves
			in_ready_o <= nxt_cnt < (AW+1)'(DEPTH);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i || clr_i) begin
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end else if (pop) begin
			out_valid_o <= 1'b1;
			out_data_o  <= mem_ff[rptr_ff];
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end

endmodule

// >>> msl_top.sv
/*
 * Per-line parameters, transmit control, modem status, transmit data
 * with break, receive silo and receive interrupt selection of an
 * eight-line asynchronous serial multiplexer.
 * Assumes the scanner, the line shifters and the control/status word
 * sit outside on the same clock; ring and carrier arrive from pins.
 */
`timescale 1ns/1ps
`include "msl_params.svh"
module msl_top #(
	parameter int CLK_HZ     = `MSL_CLK_HZ,
	parameter bit MODEM      = 1'b1,
	parameter int SILO_DEPTH = `MSL_SILO_DEPTH
) (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        master_clear_i,
	input  wire logic        maint_i,
	input  wire logic        rx_int_en_i,
	input  wire logic        alarm_en_i,
	input  wire logic [1:0]  reg_sel_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [15:0] reg_wdata_i,
	output logic      [15:0] reg_rdata_o,
	input  wire logic [2:0]  tx_line_i,
	output logic             tx_valid_o,
	input  wire logic        tx_ready_i,
	output logic      [2:0]  tx_line_o,
	output logic      [7:0]  tx_char_o,
	output logic             tx_par_en_o,
	output logic             tx_par_bit_o,
	output logic             tx_room_o,
	output logic      [7:0]  break_o,
	output logic      [7:0]  tx_enable_o,
	output logic      [7:0]  dtr_o,
	input  wire logic [7:0]  ring_i,
	input  wire logic [7:0]  carrier_i,
	input  wire logic        rx_valid_i,
	output logic             rx_ready_o,
	input  wire logic [2:0]  rx_line_i,
	input  wire logic [7:0]  rx_char_i,
	input  wire logic        rx_par_i,
	input  wire logic        rx_frame_err_i,
	input  wire logic        rx_overrun_i,
	output logic             receive_done_o,
	output logic             silo_alarm_flag_o,
	output logic             rx_irq_o,
	output logic      [31:0] data_bits_o,
	output logic      [23:0] stop_half_o,
	output logic      [7:0]  par_en_o,
	output logic      [7:0]  par_odd_o,
	output logic      [7:0]  tx_tick_o,
	output logic      [7:0]  rx_tick_o
);
	if (CLK_HZ < 16 * 9600 || CLK_HZ / 800 > 65535) begin : g_bad_clk
		$error("msl_top clock outside the divider range");
	end

	// Mask off bits above the selected length
	function automatic logic [7:0] mask_char(input logic [7:0] c, input msl_pkg::msl_len_t len);
		mask_char = c & (8'hFF >> (2'h3 - len));
	endfunction
	function automatic logic par_of(input logic [7:0] c, input logic odd);
		par_of = (^c) ^ odd;
	endfunction
	// Clock cycles per oversample tick; zero marks the unused code
	function automatic logic [15:0] div_of(input logic [3:0] code);
		case (code)
		4'h0: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_0));
		4'h1: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_1));
		4'h2: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_2));
		4'h3: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_3));
		4'h4: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_4));
		4'h5: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_5));
		4'h6: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_6));
		4'h7: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_7));
		4'h8: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_8));
		4'h9: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_9));
		4'hA: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_10));
		4'hB: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_11));
		4'hC: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_12));
		4'hD: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_13));
		4'hE: div_of = 16'(CLK_HZ * 10 / (`MSL_OVERSAMPLE * `MSL_BAUD10_14));
		default: div_of = 16'h0000;
		endcase
	endfunction

	msl_pkg::msl_lparam_t lp_ff [8];
	logic        clr;
	logic        wr_lpar;
	logic        wr_tctrl;
	logic        wr_tdata;
	logic        rd_rxbuf;
	logic [7:0]  brk_ff;
	logic [7:0]  ring_m_ff;
	logic [7:0]  ring_s_ff;
	logic [7:0]  car_m_ff;
	logic [7:0]  car_s_ff;
	logic [4:0]  alarm_cnt_ff;
	logic [4:0]  nxt_alarm_cnt;
	logic        tx_push;
	logic        tx_in_ready;
	logic [7:0]  tx_masked;
	logic [12:0] tx_word;
	logic        rx_push;
	logic        rx_accept;
	logic [7:0]  rx_masked;
	logic        rx_perr;
	logic [14:0] rx_word;
	logic        silo_valid;
	logic [14:0] silo_data;
	msl_pkg::msl_lparam_t lp_wr;
	msl_pkg::msl_lparam_t lp_tx;
	msl_pkg::msl_lparam_t lp_rx;
	assign clr      = master_clear_i;
	assign wr_lpar  = reg_wr_i && reg_sel_i == `MSL_SEL_LPAR_RXBUF;
	assign wr_tctrl = reg_wr_i && reg_sel_i == `MSL_SEL_TCTRL;
	assign wr_tdata = reg_wr_i && reg_sel_i == `MSL_SEL_TDATA_MSTAT;
	assign rd_rxbuf = reg_rd_i && reg_sel_i == `MSL_SEL_LPAR_RXBUF;
	assign lp_wr    = msl_pkg::msl_lparam_t'(reg_wdata_i[`MSL_LP_RXON_BIT:`MSL_LP_LEN_LSB]);

	// Line parameter store; bits 12 to 3 of the word land in the chosen line
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 8; i++) begin
			if (!nrst_i || clr) begin
				lp_ff[i] <= '0;
			end else if (wr_lpar && reg_wdata_i[`MSL_LP_LINE_LSB +: 3] == 3'(i)) begin
				lp_ff[i] <= lp_wr;
			end
		end
	end

	// Format outputs per line
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 8; i++) begin
			data_bits_o[4*i +: 4] <= 4'h5 + {2'h0, lp_ff[i].len};
			if (!lp_ff[i].stop2) begin
				stop_half_o[3*i +: 3] <= 3'h2;
			end else if (lp_ff[i].len == msl_pkg::MSL_LEN5) begin
				stop_half_o[3*i +: 3] <= 3'h3;
			end else begin
				stop_half_o[3*i +: 3] <= 3'h4;
			end
			par_en_o[i]  <= lp_ff[i].par_en;
			par_odd_o[i] <= lp_ff[i].par_en & lp_ff[i].odd;
		end
	end

	// One divider per line feeds both directions at the same rate
	for (genvar g = 0; g < 8; g++) begin : g_baud
		logic [15:0] cnt_ff;
		logic [15:0] div;
		assign div = div_of(lp_ff[g].speed);
		always_ff @(posedge clk_i) begin
			if (!nrst_i || clr || div == 16'h0000) begin
				cnt_ff       <= 16'h0000;
				tx_tick_o[g] <= 1'b0;
				rx_tick_o[g] <= 1'b0;
			end else if (cnt_ff >= div - 16'h0001) begin
				cnt_ff       <= 16'h0000;
				tx_tick_o[g] <= 1'b1;
				rx_tick_o[g] <= lp_ff[g].rx_on;
			end else begin
				cnt_ff       <= cnt_ff + 16'h0001;
				tx_tick_o[g] <= 1'b0;
				rx_tick_o[g] <= 1'b0;
			end
		end
	end

	// Transmit control: line enables and terminal-ready
	always_ff @(posedge clk_i) begin
		if (!nrst_i || clr) begin
			tx_enable_o <= 8'h00;
		end else if (wr_tctrl) begin
			tx_enable_o <= reg_wdata_i[7:0];
		end
	end
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !MODEM) begin
			dtr_o <= 8'h00;
		end else if (wr_tctrl) begin
			dtr_o <= reg_wdata_i[15:8];
		end
	end

	// Pin synchronisers for ring and carrier; never cleared
	always_ff @(posedge clk_i) begin
		ring_m_ff <= ring_i;
		ring_s_ff <= ring_m_ff;
		car_m_ff  <= carrier_i;
		car_s_ff  <= car_m_ff;
	end

	// Break byte; maintenance loops the line back so break is masked
	always_ff @(posedge clk_i) begin
		if (!nrst_i || clr) begin
			brk_ff <= 8'h00;
		end else if (wr_tdata) begin
			brk_ff <= reg_wdata_i[15:8];
		end
	end
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			break_o <= 8'h00;
		end else begin
			break_o <= brk_ff & {8{!maint_i}};
		end
	end

	// Transmit character path; a disabled line drops the character
	assign lp_tx     = lp_ff[tx_line_i];
	assign tx_masked = mask_char(reg_wdata_i[7:0], lp_tx.len);
	assign tx_push   = wr_tdata && tx_enable_o[tx_line_i] && !clr;
	assign tx_word   = {lp_tx.par_en, par_of(tx_masked, lp_tx.odd), tx_line_i, tx_masked};

	msl_fifo #(
		.WIDTH (13),
		.DEPTH (`MSL_TXBUF_DEPTH)
	) u_txbuf (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.clr_i       (clr),
		.in_valid_i  (tx_push),
		.in_data_i   (tx_word),
		.in_ready_o  (tx_in_ready),
		.out_valid_o (tx_valid_o),
		.out_data_o  ({tx_par_en_o, tx_par_bit_o, tx_line_o, tx_char_o}),
		.out_ready_i (tx_ready_i)
	);
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			tx_room_o <= 1'b0;
		end else begin
			tx_room_o <= tx_in_ready && !tx_push;
		end
	end

	// Receive path into the silo; lines with receiver off are dropped
	assign lp_rx     = lp_ff[rx_line_i];
	assign rx_masked = mask_char(rx_char_i, lp_rx.len);
	assign rx_perr   = lp_rx.par_en && (rx_par_i != par_of(rx_masked, lp_rx.odd));
	assign rx_word   = {rx_overrun_i, rx_frame_err_i, rx_perr, 1'b0, rx_line_i, rx_masked};
	assign rx_accept = rx_valid_i && lp_rx.rx_on;
	assign rx_push   = rx_accept && rx_ready_o;

	msl_fifo #(
		.WIDTH (15),
		.DEPTH (SILO_DEPTH)
	) u_silo (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.clr_i       (clr),
		.in_valid_i  (rx_accept),
		.in_data_i   (rx_word),
		.in_ready_o  (rx_ready_o),
		.out_valid_o (silo_valid),
		.out_data_o  (silo_data),
		.out_ready_i (rd_rxbuf)
	);

	// Register read port; the unused select 3 reads as zero
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			case (reg_sel_i)
			`MSL_SEL_LPAR_RXBUF: reg_rdata_o <= {silo_valid, silo_data};
			`MSL_SEL_TCTRL: reg_rdata_o <= {dtr_o, tx_enable_o};
			`MSL_SEL_TDATA_MSTAT: reg_rdata_o <= MODEM ? {car_s_ff, ring_s_ff} : 16'h0000;
			default: reg_rdata_o <= 16'h0000;
			endcase
		end
	end

	// Alarm counts entries since the last buffer read; an entry in the read's cycle still counts
	always_comb begin
		nxt_alarm_cnt = (rd_rxbuf ? 5'h00 : alarm_cnt_ff) + 5'(rx_push);
	end
	always_ff @(posedge clk_i) begin
		if (!nrst_i || clr) begin
			alarm_cnt_ff      <= 5'h00;
			silo_alarm_flag_o <= 1'b0;
		end else if (nxt_alarm_cnt == `MSL_ALARM_COUNT) begin
			alarm_cnt_ff      <= 5'h00;
			silo_alarm_flag_o <= 1'b1;
		end else begin
			alarm_cnt_ff <= nxt_alarm_cnt;
			if (rd_rxbuf) begin
				silo_alarm_flag_o <= 1'b0;
			end
		end
	end

	// Interrupt selection from the two enables
	always_ff @(posedge clk_i) begin
		if (!nrst_i || clr) begin
			receive_done_o <= 1'b0;
			rx_irq_o       <= 1'b0;
		end else begin
			receive_done_o <= silo_valid;
			if (!rx_int_en_i) begin
				rx_irq_o <= 1'b0;
			end else if (alarm_en_i) begin
				rx_irq_o <= silo_alarm_flag_o;
			end else begin
				rx_irq_o <= silo_valid;
			end
		end
	end
endmodule

// >>> msl_properties.sv
/* Port checker for msl_top, attached by bind after the module.
   Sees only top-level ports; one clock with a synchronous reset. */
`timescale 1ns/1ps
module msl_properties (
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        master_clear_i,
	input wire logic        maint_i,
	input wire logic        rx_int_en_i,
	input wire logic        alarm_en_i,
	input wire logic [1:0]  reg_sel_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic        rx_valid_i,
	input wire logic        rx_ready_o,
	input wire logic        receive_done_o,
	input wire logic        silo_alarm_flag_o,
	input wire logic        rx_irq_o,
	input wire logic [7:0]  break_o,
	input wire logic [7:0]  tx_enable_o,
	input wire logic [7:0]  dtr_o
);
	logic [7:0] brk_ff;
	logic       push;
	assign push = rx_valid_i && rx_ready_o;
	// Shadow of the last break byte, so the lagged output can be judged
	always_ff @(posedge clk_i) begin
		if (!nrst_i || master_clear_i)
			brk_ff <= 8'h00;
		else if (reg_wr_i && reg_sel_i == 2'h2)
			brk_ff <= reg_wdata_i[15:8];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_idle_empty;
		(!receive_done_o && !push)[*3];
	endsequence
	sequence s_buf_read;
		reg_rd_i && reg_sel_i == 2'h0;
	endsequence
	AST_INIT_CLEAR: assert property (
		$rose(nrst_i) |-> tx_enable_o == 8'h00 && dtr_o == 8'h00 && !receive_done_o)
		else $error("init left state behind");
	AST_CLR_ENABLES: assert property (
		master_clear_i |=> tx_enable_o == 8'h00 && !silo_alarm_flag_o)
		else $error("clear left enables or alarm");
	AST_DTR_HOLD: assert property (
		master_clear_i && !reg_wr_i |=> dtr_o == $past(dtr_o))
		else $error("clear changed terminal ready");
	AST_BREAK_MAINT: assert property (maint_i |=> break_o == 8'h00)
		else $error("break active in maintenance");
	AST_BREAK_FOLLOW: assert property (
		(!maint_i && !master_clear_i && !(reg_wr_i && reg_sel_i == 2'h2))[*3]
		|-> break_o == brk_ff)
		else $error("break output differs from written byte");
	AST_IRQ_OFF: assert property (!rx_int_en_i |=> !rx_irq_o)
		else $error("interrupt with receive enable clear");
	AST_IRQ_DONE: assert property (
		(rx_int_en_i && !alarm_en_i && receive_done_o)[*2] |-> rx_irq_o)
		else $error("no interrupt while receive done");
	AST_IRQ_ALARM: assert property (
		(rx_int_en_i && alarm_en_i)[*2] ##0 $stable(silo_alarm_flag_o)
		|-> rx_irq_o == silo_alarm_flag_o)
		else $error("alarm interrupt wrong");
	AST_ALARM_CLR: assert property (!push ##1 s_buf_read ##0 !push |=> !silo_alarm_flag_o)
		else $error("buffer read kept alarm");
	AST_EMPTY_READ: assert property (s_idle_empty ##0 s_buf_read |=> !reg_rdata_o[15])
		else $error("empty silo read valid");
endmodule

bind msl_top msl_properties u_props (.clk_i, .nrst_i, .master_clear_i, .maint_i, .rx_int_en_i,
	.alarm_en_i, .reg_sel_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .rx_valid_i,
	.rx_ready_o, .receive_done_o, .silo_alarm_flag_o, .rx_irq_o, .break_o, .tx_enable_o,
	.dtr_o);

// >>> msl_host_model.sv
/* Host processor model on the register port.
   Assumes the bench calls its tasks; drives on the falling edge. */
`timescale 1ns/1ps
module msl_host_model (
	input  wire logic        clk_i,
	output logic      [1:0]  reg_sel_o,
	output logic             reg_wr_o,
	output logic             reg_rd_o,
	output logic      [15:0] reg_wdata_o
);
	initial begin
		reg_sel_o = 2'h3;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 16'h0000;
	end
	// Whole words only; write-only words are never read back and merged
	task automatic wr(input logic [1:0] sel, input logic [15:0] d);
		@(negedge clk_i);
		reg_sel_o = sel;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clk_i);
		reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
	endtask
	task automatic rd(input logic [1:0] sel);
		@(negedge clk_i);
		reg_sel_o = sel;
		reg_rd_o = 1'b1;
		@(negedge clk_i);
		reg_rd_o = 1'b0;
	endtask
endmodule

// >>> tb_top.sv
/* Self-checking bench for msl_top with the host model on its register port.
   Assumes design, checker and host model are compiled first. */
`timescale 1ns/1ps
module tb_top;
	localparam int CLK_HZ = 800000;
	localparam int BAUD10[15] = '{500, 750, 1100, 1345, 1500, 3000, 6000, 12000, 18000,
		20000, 24000, 36000, 48000, 72000, 96000};
	logic        clk_i = 1'b0, nrst_i = 1'b0, master_clear_i = 1'b0, maint_i = 1'b0;
	logic        rx_int_en_i = 1'b0, alarm_en_i = 1'b0, tx_ready_i = 1'b0, rx_valid_i = 1'b0;
	logic        rx_par_i = 1'b0, rx_frame_err_i = 1'b0, rx_overrun_i = 1'b0;
	logic [2:0]  tx_line_i = 3'h0, rx_line_i = 3'h0;
	logic [7:0]  rx_char_i = 8'h00, ring_i = 8'h00, carrier_i = 8'h00;
	logic [1:0]  reg_sel_i;
	logic [15:0] reg_wdata_i, reg_rdata_o;
	logic        reg_wr_i, reg_rd_i, tx_valid_o, tx_par_en_o, tx_par_bit_o, tx_room_o;
	logic        rx_ready_o, receive_done_o, silo_alarm_flag_o, rx_irq_o;
	logic [2:0]  tx_line_o;
	logic [7:0]  tx_char_o, break_o, tx_enable_o, dtr_o, par_en_o, par_odd_o;
	logic [7:0]  tx_tick_o, rx_tick_o;
	logic [31:0] data_bits_o;
	logic [23:0] stop_half_o;
	logic [31:0] lf = 32'h8B74;
	logic [15:0] exp_rd[$], msk_rd[$];
	logic [12:0] exp_tx[$];
	logic        rd_seen = 1'b0;
	int          fails = 0, check_count = 0;

	msl_top #(.CLK_HZ(CLK_HZ)) dut (.clk_i, .nrst_i, .master_clear_i, .maint_i, .rx_int_en_i,
		.alarm_en_i, .reg_sel_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .tx_line_i,
		.tx_valid_o, .tx_ready_i, .tx_line_o, .tx_char_o, .tx_par_en_o, .tx_par_bit_o,
		.tx_room_o, .break_o, .tx_enable_o, .dtr_o, .ring_i, .carrier_i, .rx_valid_i,
		.rx_ready_o, .rx_line_i, .rx_char_i, .rx_par_i, .rx_frame_err_i, .rx_overrun_i,
		.receive_done_o, .silo_alarm_flag_o, .rx_irq_o, .data_bits_o, .stop_half_o,
		.par_en_o, .par_odd_o, .tx_tick_o, .rx_tick_o);
	msl_host_model host (.clk_i, .reg_sel_o(reg_sel_i), .reg_wr_o(reg_wr_i),
		.reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));

	always #50 clk_i = ~clk_i;

	function automatic logic [15:0] rnd();
		lf = lf[0] ? ((lf >> 1) ^ 32'h8020_0003) : (lf >> 1);
		return lf[15:0];
	endfunction
	task automatic test_done();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic hang(input string what);
		$display("[FAIL] %s expected done seen timeout", what);
		fails++;
		test_done();
	endtask
	task automatic xrd(input logic [1:0] sel, input logic [15:0] e, input logic [15:0] m);
		exp_rd.push_back(e);
		msk_rd.push_back(m);
		host.rd(sel);
	endtask
	task automatic push(input logic [2:0] ln, input logic [7:0] ch, input logic [2:0] fl);
		int n;
		@(negedge clk_i);
		rx_line_i = ln;
		rx_char_i = ch;
		{rx_par_i, rx_frame_err_i, rx_overrun_i} = fl;
		rx_valid_i = 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (!rx_ready_o && n < 50);
		if (n == 50)
			hang("receive accept");
		@(negedge clk_i);
		rx_valid_i = 1'b0;
		rx_char_i = ~ch;
	endtask

	always @(posedge clk_i) rd_seen <= reg_rd_i;
	// Read data lands one edge after the strobe; judged on the falling edge
	always @(negedge clk_i) begin
		if (rd_seen && exp_rd.size() != 0)
			chk("read word", exp_rd.pop_front(), reg_rdata_o & msk_rd.pop_front());
	end
	always @(posedge clk_i) begin
		if (nrst_i && tx_valid_o && tx_ready_i)
			chk("tx word", exp_tx.size() != 0 ? {3'h0, exp_tx.pop_front()} : 16'hFFFF,
				{3'h0, tx_line_o, tx_char_o, tx_par_en_o, tx_par_bit_o});
	end

	initial begin
		logic [15:0] r, c, wl[8];
		int n, t, x;
		repeat (12) @(negedge clk_i);
		nrst_i = 1'b1;
		xrd(2'h1, 16'h0000, 16'hFFFF);
		xrd(2'h3, 16'h0000, 16'hFFFF);
		r = rnd();
		{carrier_i, ring_i} = r;
		repeat (3) @(negedge clk_i);
		xrd(2'h2, r, 16'hFFFF);
		for (int i = 0; i < 8; i++) begin
			wl[i] = (rnd() & 16'h1FF8) | 16'(i);
			host.wr(2'h0, wl[i]);
		end
		repeat (2) @(negedge clk_i);
		for (int i = 0; i < 8; i++) begin
			chk("data bits", 16'(wl[i][4:3]) + 16'd5, 16'(data_bits_o[i*4 +: 4]));
			chk("stop half", wl[i][5] ? (wl[i][4:3] == 2'b00 ? 16'd3 : 16'd4) : 16'd2,
				16'(stop_half_o[i*3 +: 3]));
			chk("parity mode", {14'h0, wl[i][6], wl[i][6] & wl[i][7]},
				{14'h0, par_en_o[i], par_odd_o[i]});
		end
		host.wr(2'h0, 16'h0E45);
		host.wr(2'h1, 16'hA520);
		xrd(2'h1, 16'hA520, 16'hFFFF);
		tx_line_i = 3'h2;
		host.wr(2'h2, 16'h0055);
		tx_line_i = 3'h5;
		// Transmit shifter stalls: two buffer entries plus the output stage, the rest dropped
		for (int k = 0; k < 5; k++) begin
			c = rnd();
			if (k < 3)
				exp_tx.push_back({3'd5, 3'b000, c[4:0], 1'b1, ^c[4:0]});
			host.wr(2'h2, {8'h00, c[7:0]});
			repeat (2) @(negedge clk_i);
		end
		chk("tx room when full", 16'h0, {15'h0, tx_room_o});
		n = 0;
		while (exp_tx.size() != 0 && n < 200) begin
			@(negedge clk_i);
			r = rnd();
			tx_ready_i = r[0];
			n++;
		end
		if (n == 200)
			hang("tx drain");
		@(negedge clk_i);
		tx_ready_i = 1'b1;
		tx_line_i = 3'h2;
		host.wr(2'h2, 16'h2400);
		repeat (3) @(negedge clk_i);
		chk("break", 16'h0024, {8'h00, break_o});
		chk("tx room when empty", 16'h1, {15'h0, tx_room_o});
		maint_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk("break in maint", 16'h0000, {8'h00, break_o});
		maint_i = 1'b0;
		master_clear_i = 1'b1;
		@(negedge clk_i);
		master_clear_i = 1'b0;
		repeat (2) @(negedge clk_i);
		xrd(2'h1, 16'hA500, 16'hFFFF);
		xrd(2'h2, {carrier_i, ring_i}, 16'hFFFF);
		chk("break after clear", 16'h0000, {8'h00, break_o});
		chk("params after clear", 16'h0000, {8'h00, par_en_o});
		nrst_i = 1'b0;
		repeat (2) @(negedge clk_i);
		nrst_i = 1'b1;
		xrd(2'h1, 16'h0000, 16'hFFFF);
		host.wr(2'h0, 16'h1ECB);
		rx_int_en_i = 1'b1;
		alarm_en_i = 1'b1;
		push(3'h2, 8'hA5, 3'b000);
		for (int k = 0; k < 16; k++) begin
			c = rnd();
			push(3'h3, c[7:0], {~^c[5:0] ^ c[8], c[9], c[10]});
			exp_rd.push_back({1'b1, c[10], c[9], c[8], 1'b0, 3'd3, 2'b00, c[5:0]});
			msk_rd.push_back(16'hFFFF);
			if (k == 14) begin
				repeat (4) @(negedge clk_i);
				chk("alarm early", 16'h0, {15'h0, silo_alarm_flag_o});
			end
		end
		repeat (4) @(negedge clk_i);
		chk("alarm and irq", 16'h3, {14'h0, silo_alarm_flag_o, rx_irq_o});
		for (int k = 0; k < 16; k++)
			host.rd(2'h0);
		repeat (4) @(negedge clk_i);
		xrd(2'h0, 16'h0000, 16'h8000);
		alarm_en_i = 1'b0;
		push(3'h3, 8'h01, 3'b000);
		exp_rd.push_back(16'h8301);
		msk_rd.push_back(16'hFFFF);
		repeat (4) @(negedge clk_i);
		chk("irq on done", 16'h1, {15'h0, rx_irq_o});
		rx_int_en_i = 1'b0;
		repeat (2) @(negedge clk_i);
		chk("done without irq", 16'h2, {14'h0, receive_done_o, rx_irq_o});
		host.rd(2'h0);
		for (int s = 0; s < 17; s++) begin
			host.wr(2'h0, s < 16 ? 16'h1000 | 16'(s << 8) : 16'h0E00);
			repeat (1100) @(negedge clk_i);
			t = 0;
			x = 0;
			repeat (2000) begin
				@(posedge clk_i);
				t += tx_tick_o[0];
				x += rx_tick_o[0];
			end
			n = s == 15 ? 0 : 2000 / ((CLK_HZ * 10) / (16 * BAUD10[s == 16 ? 14 : s]));
			chk("tx tick count", 16'h1, 16'(t >= n - 1 && t <= n + 1));
			chk("rx tick count", 16'h1, s < 16 ? 16'(x >= n - 1 && x <= n + 1) : 16'(x == 0));
		end
		test_done();
	end
endmodule
